/* rtl/sapc_top.v */
// Purpose: control logic of a 12-bit successive-approximation converter with a parallel host port
// Assumes: host pins and comparator are asynchronous to clk and are synchronised here
// Notes: internal conversion clock is derived from clk; external conversion clock is sampled as a pin
`include "sapc_regs.vh"

module sapc_top #(
	parameter CLK_PERIOD_NS = `SAPC_CLK_PERIOD_NS,
	parameter POR_TIME_NS = `SAPC_POR_TIME_NS,
	parameter INT_CONV_TIME_NS = `SAPC_INT_CONV_TIME_NS
) (
	input wire clk,
	input wire rst,
	input wire cs_n,
	input wire wr_n,
	input wire rd_n,
	input wire conv_clk_pin,
	input wire [`SAPC_CB_W-1:0] data_in,
	input wire comp_above,
	output reg [`SAPC_RES_W-1:0] data_out_q,
	output reg data_oe_n_q,
	output reg done_n_q,
	output reg done_oe_n_q,
	output reg tracking_q,
	output reg [`SAPC_RES_W-1:0] dac_code_q,
	output reg converting_q,
	output reg [1:0] power_state_q,
	output reg ext_clk_mode_q,
	output reg acquisition_select_q,
	output reg input_config_select_q,
	output reg polarity_select_q,
	output reg channel_addr_bit2_q,
	output reg channel_addr_bit1_q,
	output reg channel_addr_bit0_q
);

	// ****************************************************************
	// limits seen from the pins
	// ****************************************************************
	// every pin passes two flip-flops, so the host sees these latencies:
	// a write is taken 2 to 3 clk after its strobe rises, fields update on that same clk;
	// the data pins must settle 3 clk before that rise and hold 1 clk after it;
	// the data pins drive 3 clk after chip select and read strobe are both low;
	// the external conversion clock needs 3 clk high and 3 clk low or edges are lost;
	// strobes closer together than about 6 clk may be seen as a single edge

	// ****************************************************************
	// derived cycle counts
	// ****************************************************************
	// least time, rounded up
	localparam POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// longest time, rounded down, so the conversion never exceeds its time
	localparam INT_DIV_RAW = INT_CONV_TIME_NS / (`SAPC_CONV_CYCLES * CLK_PERIOD_NS);
	localparam INT_DIV = (INT_DIV_RAW < 1) ? 1 : INT_DIV_RAW;
	localparam integer POR_LAST_I = POR_CYCLES - 1;
	localparam integer INT_DIV_LAST_I = INT_DIV - 1;
	localparam integer CONV_LAST_I = `SAPC_CONV_CYCLES - 1;
	localparam integer ACQ_LAST_I = `SAPC_ACQ_FALLS - 1;
	// end points cut on purpose to the width of the counter that meets them
	localparam [15:0] POR_LAST = POR_LAST_I[15:0];
	localparam [15:0] INT_DIV_LAST = INT_DIV_LAST_I[15:0];
	localparam [3:0] CONV_LAST = CONV_LAST_I[3:0];
	localparam [2:0] ACQ_LAST = ACQ_LAST_I[2:0];

	localparam ST_IDLE = 3'h0;
	localparam ST_ACQ_INT = 3'h1;
	localparam ST_ACQ_EXT = 3'h2;
	localparam ST_CONV = 3'h3;
	localparam ST_PD = 3'h4;

	// power mode with the top bit set is normal operation
	function pm_is_normal;
		input [1:0] pm;
		begin
			pm_is_normal = pm[1];
		end
	endfunction

	// falling edge between the second and third synchroniser stages
	function stage_fell;
		input [2:0] s;
		begin
			stage_fell = ~s[1] & s[2];
		end
	endfunction

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	reg [1:0] cs_n_s_q;
	reg [2:0] wr_n_s_q;
	reg [2:0] rd_n_s_q;
	reg [2:0] cclk_s_q;
	reg [1:0] comp_s_q;
	reg [`SAPC_CB_W-1:0] din_s1_q;
	reg [`SAPC_CB_W-1:0] din_s2_q;

	always @(posedge clk) begin
		if (rst) begin
			cs_n_s_q <= 2'h3;
			wr_n_s_q <= 3'h7;
			rd_n_s_q <= 3'h7;
			cclk_s_q <= 3'h0;
			comp_s_q <= 2'h0;
			din_s1_q <= 8'h00;
			din_s2_q <= 8'h00;
		end else begin
			cs_n_s_q <= {cs_n_s_q[0], cs_n};
			wr_n_s_q <= {wr_n_s_q[1:0], wr_n};
			rd_n_s_q <= {rd_n_s_q[1:0], rd_n};
			cclk_s_q <= {cclk_s_q[1:0], conv_clk_pin};
			comp_s_q <= {comp_s_q[0], comp_above};
			din_s1_q <= data_in;
			din_s2_q <= din_s1_q;
		end
	end

	wire cs_act = ~cs_n_s_q[1];
	wire comp_s = comp_s_q[1];
	// edges look only at the second and third stages
	wire wr_rise = wr_n_s_q[1] & ~wr_n_s_q[2] & cs_act;
	wire rd_fall = stage_fell(rd_n_s_q) & cs_act;
	wire ext_fall = stage_fell(cclk_s_q) & cs_act;

	// ****************************************************************
	// power-on hold-off
	// ****************************************************************
	reg [15:0] por_cnt_q;
	reg por_done_q;

	always @(posedge clk) begin
		if (rst) begin
			por_cnt_q <= 16'h0000;
			por_done_q <= 1'b0;
		end else if (!por_done_q) begin
			if (por_cnt_q == POR_LAST) begin
				por_done_q <= 1'b1;
			end else begin
				por_cnt_q <= por_cnt_q + 16'h0001;
			end
		end
	end

	// writes during the hold-off are dropped, so no conversion can start
	wire wr_take = wr_rise & por_done_q;
	wire [1:0] new_pm = {din_s2_q[`SAPC_CB_PM_HI], din_s2_q[`SAPC_CB_PM_LO]};
	wire new_acq = din_s2_q[`SAPC_CB_ACQ];

	// ****************************************************************
	// conversion clock
	// ****************************************************************
	reg [15:0] div_cnt_q;
	reg int_tick_q;

	always @(posedge clk) begin
		if (rst) begin
			div_cnt_q <= 16'h0000;
			int_tick_q <= 1'b0;
		end else if (wr_take) begin
			// a free-running divider would cut the first period after a write short,
			// so acquisition and conversion would both come out short
			div_cnt_q <= 16'h0000;
			int_tick_q <= 1'b0;
		end else if (div_cnt_q == INT_DIV_LAST) begin
			div_cnt_q <= 16'h0000;
			int_tick_q <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
			int_tick_q <= 1'b0;
		end
	end

	// one pulse per falling edge of the internal conversion clock, or of the external one while chip select is low
	wire cc_fall = ext_clk_mode_q ? ext_fall : int_tick_q;

	// ****************************************************************
	// control byte and sequencer
	// ****************************************************************
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [2:0] acq_cnt_q;
	reg [3:0] conv_cnt_q;
	reg [`SAPC_RES_W-1:0] mask_q;
	reg [`SAPC_RES_W-1:0] result_q;
	reg conv_pol_q;
	wire conv_done = (state_q == ST_CONV) & cc_fall & (conv_cnt_q == CONV_LAST);

	always @* begin
		state_d = state_q;
		if (wr_take) begin
			if (!pm_is_normal(new_pm)) begin
				state_d = ST_PD;
			end else if (new_acq) begin
				state_d = ST_ACQ_EXT;
			end else if (state_q == ST_ACQ_EXT) begin
				state_d = ST_CONV;
			end else begin
				state_d = ST_ACQ_INT;
			end
		end else begin
			case (state_q)
				ST_ACQ_INT: begin
					if (cc_fall && acq_cnt_q == ACQ_LAST) begin
						state_d = ST_CONV;
					end
				end
				ST_CONV: begin
					if (conv_done) begin
						state_d = ST_IDLE;
					end
				end
				default: begin
					state_d = state_q;
				end
			endcase
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			ext_clk_mode_q <= 1'b1;
			power_state_q <= `SAPC_PM_NORM_EXT;
			acquisition_select_q <= 1'b0;
			input_config_select_q <= 1'b0;
			polarity_select_q <= 1'b0;
			channel_addr_bit2_q <= 1'b0;
			channel_addr_bit1_q <= 1'b0;
			channel_addr_bit0_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (wr_take) begin
				// any write wakes the part; a power-down byte sends it back down
				power_state_q <= new_pm;
				if (pm_is_normal(new_pm)) begin
					ext_clk_mode_q <= new_pm[0];
				end
				acquisition_select_q <= new_acq;
				input_config_select_q <= din_s2_q[`SAPC_CB_SGL];
				polarity_select_q <= din_s2_q[`SAPC_CB_UNI];
				channel_addr_bit2_q <= din_s2_q[`SAPC_CB_CH_HI];
				channel_addr_bit1_q <= din_s2_q[`SAPC_CB_CH_LO + 1];
				channel_addr_bit0_q <= din_s2_q[`SAPC_CB_CH_LO];
			end
		end
	end

	// ****************************************************************
	// acquisition and successive approximation
	// ****************************************************************
	always @(posedge clk) begin
		if (rst) begin
			acq_cnt_q <= 3'h0;
			conv_cnt_q <= 4'h0;
			mask_q <= `SAPC_RES_ZERO;
			dac_code_q <= `SAPC_RES_ZERO;
			result_q <= `SAPC_RES_ZERO;
			conv_pol_q <= 1'b0;
			tracking_q <= 1'b0;
			converting_q <= 1'b0;
		end else begin
			converting_q <= (state_d == ST_CONV);
			if (state_d == ST_ACQ_INT || state_d == ST_ACQ_EXT) begin
				tracking_q <= 1'b1;
			end else begin
				tracking_q <= 1'b0;
			end
			if (wr_take) begin
				acq_cnt_q <= 3'h0;
			end else if (state_q == ST_ACQ_INT && cc_fall) begin
				acq_cnt_q <= acq_cnt_q + 3'h1;
			end
			if (state_d == ST_CONV && state_q != ST_CONV) begin
				// sample taken here; first trial is mid scale
				conv_cnt_q <= 4'h0;
				mask_q <= `SAPC_RES_MSB;
				dac_code_q <= `SAPC_RES_MSB;
				conv_pol_q <= wr_take ? din_s2_q[`SAPC_CB_UNI] : polarity_select_q;
			end else if (state_q == ST_CONV && state_d == ST_CONV && cc_fall) begin
				conv_cnt_q <= conv_cnt_q + 4'h1;
				mask_q <= mask_q >> 1;
				if (comp_s) begin
					dac_code_q <= dac_code_q | (mask_q >> 1);
				end else begin
					dac_code_q <= (dac_code_q & ~mask_q) | (mask_q >> 1);
				end
			end
			if (conv_done) begin
				// after the twelfth decision the trial code is the result
				result_q <= dac_code_q;
			end
		end
	end

	// ****************************************************************
	// host port outputs
	// ****************************************************************
	// the analog side yields offset binary; flipping the top bit gives two's complement
	wire [`SAPC_RES_W-1:0] coded = conv_pol_q ? result_q :
		{~result_q[`SAPC_RES_W-1], result_q[`SAPC_RES_W-2:0]};

	always @(posedge clk) begin
		if (rst) begin
			done_n_q <= 1'b1;
			done_oe_n_q <= 1'b1;
			data_out_q <= `SAPC_RES_ZERO;
			data_oe_n_q <= 1'b1;
		end else begin
			if (conv_done) begin
				done_n_q <= 1'b0;
			end else if (rd_fall || wr_take) begin
				done_n_q <= 1'b1;
			end
			done_oe_n_q <= ~cs_act;
			data_out_q <= coded;
			// drives only while chip select and read strobe are both low
			data_oe_n_q <= ~(cs_act & ~rd_n_s_q[1]);
		end
	end

endmodule // sapc_top

/* common/sapc_regs.vh */
// Purpose: constants of the converter control block (control byte layout, modes, timing)
// Assumes: included by rtl/sapc_top.v only
// Notes: all timing figures are in their own unit; cycle counts are derived in the module
`ifndef SAPC_REGS_VH
`define SAPC_REGS_VH

// ****************************************************************
// control byte field positions
// ****************************************************************
`define SAPC_CB_W 8
`define SAPC_CB_PM_HI 7
`define SAPC_CB_PM_LO 6
`define SAPC_CB_ACQ 5
`define SAPC_CB_SGL 4
`define SAPC_CB_UNI 3
`define SAPC_CB_CH_HI 2
`define SAPC_CB_CH_LO 0

// ****************************************************************
// power mode field values
// ****************************************************************
`define SAPC_PM_FULL_PD 2'h0
`define SAPC_PM_STANDBY 2'h1
`define SAPC_PM_NORM_INT 2'h2
`define SAPC_PM_NORM_EXT 2'h3

// ****************************************************************
// result and sequencing
// ****************************************************************
`define SAPC_RES_W 12
`define SAPC_RES_ZERO 12'h000
`define SAPC_RES_MSB 12'h800
`define SAPC_CONV_CYCLES 13
`define SAPC_ACQ_FALLS 4

// ****************************************************************
// timing figures
// ****************************************************************
`define SAPC_CLK_PERIOD_NS 8
`define SAPC_POR_TIME_NS 10000
`define SAPC_INT_CONV_TIME_NS 3600

`endif

/* verification/sapc_afe_model.sv */
// Purpose: comparator in front of the successive-approximation register
// Assumes: the bench holds the sampled input as a 12-bit code
// Notes: at or above the trial code counts as above, so the search lands on the level exactly
module sapc_afe_model (
	input wire logic [11:0] dac_code_q,
	input wire logic [11:0] level,
	output logic comp_above
);
	timeunit 1ns;
	timeprecision 1ps;
	assign comp_above = level >= dac_code_q;
endmodule // sapc_afe_model

/* verification/sapc_chk.sv */
// Purpose: port-level checks of the converter control block
// Assumes: bound into sapc_top by the bench
// Notes: conversion length is only checked against the internal clock
module sapc_chk #(
	parameter CLK_PERIOD_NS = 8,
	parameter INT_CONV_TIME_NS = 3600
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic data_oe_n_q,
	input wire logic done_n_q,
	input wire logic done_oe_n_q,
	input wire logic tracking_q,
	input wire logic converting_q,
	input wire logic [1:0] power_state_q,
	input wire logic ext_clk_mode_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	localparam int CONV_CYC = INT_CONV_TIME_NS / (13 * CLK_PERIOD_NS) * 13;
	logic [15:0] conv_cnt_q;
	// ****
	// cycles spent converting, cleared between conversions
	// ****
	always @(posedge clk) begin
		conv_cnt_q <= (rst || !converting_q) ? 16'h0000 : conv_cnt_q + 16'h0001;
	end
	property p_float; cs_n [*3] |=> done_oe_n_q && data_oe_n_q; endproperty
	property p_drive; !data_oe_n_q |-> $past(!cs_n && !rd_n, 3); endproperty
	property p_rd_clear; !done_n_q && !cs_n && $fell(rd_n) |-> ##[2:4] done_n_q; endproperty
	property p_done_end; $fell(converting_q) && !tracking_q && power_state_q[1] |-> !done_n_q; endproperty
	property p_conv_len;
		$fell(converting_q) && !tracking_q && !ext_clk_mode_q && power_state_q[1]
			|-> conv_cnt_q >= CONV_CYC - 2 && conv_cnt_q <= CONV_CYC + 2;
	endproperty
	property p_reset; $fell(rst) |-> done_n_q && done_oe_n_q && ext_clk_mode_q && power_state_q == 2'h3; endproperty
	property p_clk_keep; $changed(ext_clk_mode_q) |-> power_state_q[1]; endproperty
	property p_pd_idle; !power_state_q[1] |-> !converting_q && !tracking_q; endproperty
	a_float: assert property (p_float) else $error("pins driven while deselected");
	a_drive: assert property (p_drive) else $error("data driven without read");
	a_rd_clear: assert property (p_rd_clear) else $error("done not cleared by read");
	a_done_end: assert property (p_done_end) else $error("done missing at end");
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
	a_reset: assert property (p_reset) else $error("reset state wrong");
	a_clk_keep: assert property (p_clk_keep) else $error("clock mode changed by power-down");
	a_pd_idle: assert property (p_pd_idle) else $error("activity in power-down");
	c_int: cover property ($fell(converting_q) && !ext_clk_mode_q);
	c_ext: cover property ($fell(converting_q) && ext_clk_mode_q);
	c_rd: cover property (!done_n_q && !cs_n && $fell(rd_n));
endmodule // sapc_chk

/* verification/tb.sv */
// Purpose: self-checking bench for the converter control block
// Assumes: hold-off shortened to 80 ns; conversion clock pin near 4.5 MHz
// Notes: each conversion queues its coded result; a monitor checks it when done falls
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, rst = 1'h1, cs_n = 1'h1, wr_n = 1'h1, rd_n = 1'h1, conv_clk_pin = 1'h1, comp_above;
	logic [7:0] data_in = 8'h00;
	logic [11:0] level = 12'h000, data_out_q, dac_code_q;
	logic [1:0] power_state_q;
	logic data_oe_n_q, done_n_q, done_oe_n_q, tracking_q, converting_q, ext_clk_mode_q, acquisition_select_q;
	logic input_config_select_q, polarity_select_q, channel_addr_bit2_q, channel_addr_bit1_q, channel_addr_bit0_q;
	wire [5:0] fields = {acquisition_select_q, input_config_select_q, polarity_select_q, channel_addr_bit2_q,
		channel_addr_bit1_q, channel_addr_bit0_q};
	logic [11:0] exp_q[$];
	int miscompares = 0, checked = 0, seed = 90580;
	sapc_top #(.POR_TIME_NS(80)) uut (
		.clk(clk),
		.rst(rst),
		.cs_n(cs_n),
		.wr_n(wr_n),
		.rd_n(rd_n),
		.conv_clk_pin(conv_clk_pin),
		.data_in(data_in),
		.comp_above(comp_above),
		.data_out_q(data_out_q),
		.data_oe_n_q(data_oe_n_q),
		.done_n_q(done_n_q),
		.done_oe_n_q(done_oe_n_q),
		.tracking_q(tracking_q),
		.dac_code_q(dac_code_q),
		.converting_q(converting_q),
		.power_state_q(power_state_q),
		.ext_clk_mode_q(ext_clk_mode_q),
		.acquisition_select_q(acquisition_select_q),
		.input_config_select_q(input_config_select_q),
		.polarity_select_q(polarity_select_q),
		.channel_addr_bit2_q(channel_addr_bit2_q),
		.channel_addr_bit1_q(channel_addr_bit1_q),
		.channel_addr_bit0_q(channel_addr_bit0_q)
	);
	sapc_afe_model afe (.dac_code_q(dac_code_q), .level(level), .comp_above(comp_above));
	initial forever #4 clk = ~clk;
	initial forever begin
		repeat (14) @(posedge clk);
		conv_clk_pin <= ~conv_clk_pin;
	end
	// ****
	// tasks
	// ****
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [7:0] b);
		@(posedge clk);
		data_in <= b;
		wr_n <= 1'h0;
		repeat (4) @(posedge clk);
		wr_n <= 1'h1;
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic rd;
		@(posedge clk);
		rd_n <= 1'h0;
		repeat (5) @(posedge clk);
		#1;
		chk("data drive", data_oe_n_q, cs_n);
		@(posedge clk);
		rd_n <= 1'h1;
		repeat (5) @(posedge clk);
		#1;
		chk("done after read", done_n_q, !cs_n);
	endtask
	task automatic conv(input logic [7:0] b, input logic ext_acq);
		logic [11:0] v;
		int n;
		v = 12'($random(seed));
		level <= v;
		exp_q.push_back(b[3] ? v : v ^ 12'h800);
		if (ext_acq) begin
			wr(b | 8'h20);
			chk("tracking", tracking_q, 1'h1);
		end
		wr(b);
		chk("clock mode", ext_clk_mode_q, b[6]);
		chk("fields", fields, b[5:0]);
		n = 0;
		while (done_n_q !== 1'h0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk("done", done_n_q, 1'h0);
		repeat (3) @(posedge clk);
	endtask
	// result appears one cycle after done falls
	initial forever begin
		@(negedge done_n_q);
		repeat (2) @(posedge clk);
		#1;
		chk("result pending", exp_q.size() > 0, 1'h1);
		if (exp_q.size() > 0)
			chk("result", data_out_q, exp_q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		summarize;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		#1;
		chk("reset clock mode", ext_clk_mode_q, 1'h1);
		chk("reset done", done_n_q, 1'h1);
		repeat (20) @(posedge clk);
		cs_n <= 1'h0;
		for (int i = 0; i < 4; i++) begin
			conv({1'h1, i[0], 2'h1, i[0] ^ i[1], i[2:0]}, i[1]);
			rd;
		end
		wr(8'h9a);
		repeat (200) @(posedge clk);
		#1;
		chk("busy", converting_q, 1'h1);
		conv(8'h92, 1'h0);
		rd;
		for (int p = 0; p < 2; p++) begin
			wr({2'(p), 6'h1a});
			repeat (700) @(posedge clk);
			#1;
			chk("power state", power_state_q, p);
			chk("clock kept", ext_clk_mode_q, 1'h0);
			chk("idle", done_n_q, 1'h1);
		end
		conv(8'h99, 1'h0);
		cs_n <= 1'h1;
		repeat (4) @(posedge clk);
		#1;
		chk("done float", done_oe_n_q, 1'h1);
		rd;
		@(posedge clk);
		cs_n <= 1'h0;
		repeat (4) @(posedge clk);
		rd;
		summarize;
	end
endmodule // tb
bind sapc_top sapc_chk #(.CLK_PERIOD_NS(CLK_PERIOD_NS), .INT_CONV_TIME_NS(INT_CONV_TIME_NS)) mon (
	.clk(clk),
	.rst(rst),
	.cs_n(cs_n),
	.rd_n(rd_n),
	.data_oe_n_q(data_oe_n_q),
	.done_n_q(done_n_q),
	.done_oe_n_q(done_oe_n_q),
	.tracking_q(tracking_q),
	.converting_q(converting_q),
	.power_state_q(power_state_q),
	.ext_clk_mode_q(ext_clk_mode_q)
);
